// file: shared/pews_consts.svh
// timing constants and the pin layout of the paged EEPROM write controller
// What the document requires of the memory interface
// [R1] The memory finishes a page write within 10 ms (3 ms on the fast option) after the byte loads end.
// [R2] Each further byte load of a page starts no later than 150 us after the previous one.
// [R3] Every write strobe falling edge of a page load carries the same page number on the page address lines.
// [R4] With software protection active, the page number stays constant on every strobe after the unlock code.
// [R5] Output enable stays high for the whole time that write strobe and chip select are both low.
// [R6] During an internal write the toggle status line changes on each read strobe.
// [R7] Only a change between successive reads means busy; first and last values are undefined.
// [R8] Status reads may use any location, but the address is best kept unchanged across them.
// [R9] During an internal write bit 7 reads inverted, afterwards the true stored data is returned.
`ifndef PEWS_CONSTS_SVH
`define PEWS_CONSTS_SVH

`define PEWS_CLK_MHZ        50
`define PEWS_ADDR_W         15
`define PEWS_PAGE_LSB       6
`define PEWS_PAGE_BYTES     64
`define PEWS_TOGGLE_BIT     6
`define PEWS_POLL_BIT       7
`define PEWS_WP_NS          100
`define PEWS_WPH_NS         50
`define PEWS_ACC_NS         150
`define PEWS_OEHP_NS        150
`define PEWS_BLC_US         150
`define PEWS_WC_STD_MS      10
`define PEWS_WC_FAST_MS     3
`define PEWS_SYNC_STAGES    3
// least times round up, longest round down
`define PEWS_NS_UP(ns)      ((((ns) * `PEWS_CLK_MHZ) + 999) / 1000)
`define PEWS_WP_CYC         `PEWS_NS_UP(`PEWS_WP_NS)
`define PEWS_WPH_CYC        `PEWS_NS_UP(`PEWS_WPH_NS)
`define PEWS_ACC_CYC        `PEWS_NS_UP(`PEWS_ACC_NS)
`define PEWS_OEHP_CYC       `PEWS_NS_UP(`PEWS_OEHP_NS)
`define PEWS_BLC_CYC        (`PEWS_BLC_US * `PEWS_CLK_MHZ)
`define PEWS_WC_STD_CYC     (`PEWS_WC_STD_MS * 1000 * `PEWS_CLK_MHZ)
`define PEWS_WC_FAST_CYC    (`PEWS_WC_FAST_MS * 1000 * `PEWS_CLK_MHZ)

`endif

// file: shared/pews_pkg.sv
// types shared by the paged EEPROM write controller
`default_nettype none
package pews_pkg;
    typedef struct packed {
        logic [14:0] addr;
        logic [7:0]  data;
        logic        last;
    } pews_byte_t;

    typedef struct packed {
        logic        ok;
        logic        timeout;
        logic [7:0]  data;
    } pews_result_t;

    typedef struct packed {
        logic [14:0] addr;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic [7:0]  dq_out;
        logic        dq_oe_n;
    } pews_pins_t;

    typedef enum logic [2:0] {
        PEWS_IDLE      = 3'b000,
        PEWS_LOAD_LOW  = 3'b001,
        PEWS_LOAD_HIGH = 3'b010,
        PEWS_RD_LOW    = 3'b011,
        PEWS_RD_HIGH   = 3'b100,
        PEWS_DONE      = 3'b101
    } pews_state_t;
endpackage : pews_pkg
`default_nettype wire

// file: rtl/pews_host.sv
// host controller that loads a page into the EEPROM and polls for write completion
`timescale 1ns/1ps
`default_nettype none
`include "pews_consts.svh"
module pews_host #(
    parameter int BYTE_LOAD_CYC = `PEWS_BLC_CYC,
    parameter int WC_STD_CYC    = `PEWS_WC_STD_CYC,
    parameter int WC_FAST_CYC   = `PEWS_WC_FAST_CYC,
    parameter bit FAST_WRITE    = 1'b0
) (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  byte_valid,
    output logic                       byte_ready,
    input  wire pews_pkg::pews_byte_t  byte_in,
    output logic                       result_valid,
    output pews_pkg::pews_result_t     result,
    output logic                       busy,
    output pews_pkg::pews_pins_t       pins,
    input  wire logic [7:0]            eep_dq_in
);
    import pews_pkg::*;

    localparam int WC_CYC     = FAST_WRITE ? WC_FAST_CYC : WC_STD_CYC;
    localparam int LOAD_LIMIT = BYTE_LOAD_CYC - 2;

    if (BYTE_LOAD_CYC < `PEWS_WP_CYC + `PEWS_WPH_CYC + 4 || BYTE_LOAD_CYC > 65535) begin : g_blc_chk
        $error("BYTE_LOAD_CYC out of range");
    end
    if (WC_CYC < 1 || WC_CYC > 16777215) begin : g_wc_chk
        $error("write cycle count out of range");
    end

    pews_state_t  state;
    pews_state_t  next_state;
    logic [15:0]  cnt;
    logic [15:0]  gap;
    logic [23:0]  poll;
    logic [8:0]   page;
    logic [14:0]  cur_addr;
    logic [7:0]   cur_data;
    logic [6:0]   nbytes;
    logic         final_seen;
    logic         have_prev;
    logic         prev_tog;
    logic [7:0]   rd_data;
    logic [7:0]   sync1;
    logic [7:0]   sync2;
    logic [7:0]   sync3;

    wire          accept     = byte_valid && byte_ready;
    wire          page_match = byte_in.addr[14:`PEWS_PAGE_LSB] == page;
    wire          wph_met    = cnt >= 16'(`PEWS_WPH_CYC);
    wire          gap_open   = gap < 16'(LOAD_LIMIT);
    wire          page_full  = nbytes == 7'(`PEWS_PAGE_BYTES);
    wire          load_end   = wph_met && (final_seen || page_full || !gap_open || (byte_valid && !page_match));
    wire          rd_settled = cnt >= 16'(`PEWS_ACC_CYC + `PEWS_SYNC_STAGES) && sync2 == sync3;
    wire          rd_end     = cnt >= 16'(`PEWS_OEHP_CYC - 1);
    wire          tog_still  = have_prev && prev_tog == rd_data[`PEWS_TOGGLE_BIT];
    wire          timed_out  = poll >= 24'(WC_CYC);
    wire          in_load    = state == PEWS_LOAD_LOW || state == PEWS_LOAD_HIGH;

    // a new page only starts from idle; later bytes must share its page
    assign byte_ready = (state == PEWS_IDLE)
                     || (state == PEWS_LOAD_HIGH && wph_met && gap_open && page_match // R3 R4
                         && !final_seen && !page_full);                               // R2
    assign busy       = state != PEWS_IDLE;

    // strobes and bus enable decode straight from the state register, address and data come from cur_addr and cur_data
    assign pins.addr    = cur_addr;   // R8
    assign pins.ce_n    = !(state == PEWS_LOAD_LOW || state == PEWS_RD_LOW);
    assign pins.we_n    = state != PEWS_LOAD_LOW;
    assign pins.oe_n    = state != PEWS_RD_LOW;   // R5
    assign pins.dq_out  = cur_data;
    assign pins.dq_oe_n = !in_load;

    always_comb begin
        next_state = state;
        case (state)
            PEWS_IDLE:      if (accept) next_state = PEWS_LOAD_LOW;
            PEWS_LOAD_LOW:  if (cnt >= 16'(`PEWS_WP_CYC - 1)) next_state = PEWS_LOAD_HIGH;
            PEWS_LOAD_HIGH: begin
                if (accept)
                    next_state = PEWS_LOAD_LOW;
                else if (load_end)
                    next_state = PEWS_RD_LOW;
            end
            PEWS_RD_LOW:    if (rd_settled) next_state = PEWS_RD_HIGH;
            PEWS_RD_HIGH: begin
                // two equal toggle reads in a row mean the write is over
                if (rd_end && (tog_still || timed_out)) // R6 R7 R1
                    next_state = PEWS_DONE;
                else if (rd_end)
                    next_state = PEWS_RD_LOW;
            end
            PEWS_DONE:      next_state = PEWS_IDLE;
            default:        next_state = PEWS_IDLE;
        endcase
    end

    // three stages on the asynchronous data pins
    always_ff @(posedge clk) begin
        sync1 <= eep_dq_in;
        sync2 <= sync1;
        sync3 <= sync2;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= PEWS_IDLE;
            cnt   <= 16'h0000;
        end else begin
            state <= next_state;
            cnt   <= (next_state != state) ? 16'h0000 : (cnt == 16'hFFFF ? cnt : cnt + 16'h0001);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gap        <= 16'h0000;
            page       <= 9'h000;
            cur_addr   <= 15'h0000;
            cur_data   <= 8'h00;
            nbytes     <= 7'h00;
            final_seen <= 1'b0;
        end else if (accept) begin
            gap        <= 16'h0000; // R2
            page       <= byte_in.addr[14:`PEWS_PAGE_LSB];
            cur_addr   <= byte_in.addr;
            cur_data   <= byte_in.data;
            nbytes     <= nbytes + 7'h01;
            final_seen <= byte_in.last;
        end else if (state == PEWS_DONE) begin
            nbytes     <= 7'h00;
            final_seen <= 1'b0;
        end else if (in_load && gap != 16'hFFFF) begin
            gap        <= gap + 16'h0001;
        end
    end

    // polling reads the last written location, unchanged to the end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            poll      <= 24'h000000;
            have_prev <= 1'b0;
            prev_tog  <= 1'b0;
            rd_data   <= 8'h00;
        end else if (in_load) begin
            poll      <= 24'h000000;
            have_prev <= 1'b0;
        end else begin
            if ((state == PEWS_RD_LOW || state == PEWS_RD_HIGH) && !timed_out)
                poll <= poll + 24'h000001; // R1
            if (state == PEWS_RD_LOW && rd_settled)
                rd_data <= sync3;
            if (state == PEWS_RD_HIGH && rd_end) begin
                have_prev <= 1'b1;
                prev_tog  <= rd_data[`PEWS_TOGGLE_BIT];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            result_valid <= 1'b0;
            result       <= '0;
        end else begin
            result_valid <= next_state == PEWS_DONE;
            if (next_state == PEWS_DONE) begin
                // inverted bit 7 or wrong data means still busy or lost write
                result.ok      <= tog_still && rd_data == cur_data; // R9
                result.timeout <= !tog_still;
                result.data    <= rd_data;
            end
        end
    end

    property p_oe_high_in_write;
        @(posedge clk) disable iff (sys_rst) (!pins.we_n && !pins.ce_n) |-> pins.oe_n;
    endproperty
    a_oe_high_in_write: assert property (p_oe_high_in_write) else $error("oe low during write pulse"); // R5

    property p_page_on_fall;
        @(posedge clk) disable iff (sys_rst)
            ($fell(pins.we_n) && nbytes > 7'h01) |-> pins.addr[14:6] == $past(page, 2);
    endproperty
    a_page_on_fall: assert property (p_page_on_fall) else $error("page changed within load"); // R3

    property p_page_held_high;
        @(posedge clk) disable iff (sys_rst)
            (state == PEWS_LOAD_HIGH) |=> (pins.addr[14:6] == $past(pins.addr[14:6]));
    endproperty
    a_page_held_high: assert property (p_page_held_high) else $error("page moved between strobes"); // R4

    property p_gap_bound;
        @(posedge clk) disable iff (sys_rst) $fell(pins.we_n) |-> $past(gap) < 16'(BYTE_LOAD_CYC);
    endproperty
    a_gap_bound: assert property (p_gap_bound) else $error("byte load gap exceeded"); // R2

    property p_poll_addr;
        @(posedge clk) disable iff (sys_rst)
            (state == PEWS_RD_HIGH && next_state == PEWS_RD_LOW) |=> pins.addr == $past(pins.addr);
    endproperty
    a_poll_addr: assert property (p_poll_addr) else $error("poll address moved"); // R8

    property p_wp_width;
        @(posedge clk) disable iff (sys_rst) $fell(pins.we_n) |-> (!pins.we_n)[*5] ##1 pins.we_n;
    endproperty
    a_wp_width: assert property (p_wp_width) else $error("write pulse width wrong");

    property p_no_clash;
        @(posedge clk) disable iff (sys_rst) !pins.oe_n |-> (pins.dq_oe_n && pins.we_n);
    endproperty
    a_no_clash: assert property (p_no_clash) else $error("bus driven during read");

    property p_timeout;
        @(posedge clk) disable iff (sys_rst)
            (result_valid && result.timeout) |-> $past(poll) >= 24'(WC_CYC);
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout before write time"); // R1

    property p_done_stable;
        @(posedge clk) disable iff (sys_rst)
            (result_valid && !result.timeout) |-> $past(tog_still, 2);
    endproperty
    a_done_stable: assert property (p_done_stable) else $error("done without stable toggle"); // R7

    c_multi_byte: cover property (@(posedge clk) $fell(pins.we_n) && nbytes > 7'h02);
    c_done_ok:    cover property (@(posedge clk) result_valid && result.ok);
    c_timeout:    cover property (@(posedge clk) result_valid && result.timeout);
    c_gap_end:    cover property (@(posedge clk) state == PEWS_LOAD_HIGH && !gap_open);
endmodule : pews_host
`default_nettype wire

// file: sim/pews_eeprom_model.sv
// behavioural paged EEPROM on the far side of the controller
`timescale 1ns/1ps
`default_nettype none
module pews_eeprom_model #(
    parameter int WC_NS  = 2000,
    parameter int ACC_NS = 100
) (
    input  wire pews_pkg::pews_pins_t pins,
    input  wire logic [7:0]           host_dq,
    input  wire logic                 stuck,
    output logic [7:0]                mem_dq
);
    import pews_pkg::*;
    logic [7:0] mem [int];
    logic [7:0] last_wr = 8'h00;
    logic       tog = 1'b0;
    realtime    busy_until = 0;
    wire        wr_on = !pins.ce_n && !pins.we_n;
    wire        rd_on = !pins.ce_n && !pins.oe_n;
    initial mem_dq = 8'hFF;
    // latch on the closing strobe edge: address and data move with the opening one
    // timer restarts with every load, so it runs from the end of the load phase
    always @(negedge wr_on) begin
        mem[int'(pins.addr)] = host_dq;
        last_wr = host_dq;
        busy_until = $realtime + WC_NS;
    end
    // stuck holds the write open, used only by the timeout case
    always @(posedge rd_on) begin
        mem_dq = ~mem_dq;
        if (stuck || $realtime < busy_until) begin
            tog = ~tog;
            #(ACC_NS) mem_dq = {~last_wr[7], tog, 6'h2A};
        end else begin
            #(ACC_NS) mem_dq = mem.exists(int'(pins.addr)) ? mem[int'(pins.addr)] : 8'hFF;
        end
    end
    // released bus has no pull, so show the inverse of the last value
    always @(negedge rd_on) mem_dq = ~mem_dq;
endmodule : pews_eeprom_model
`default_nettype wire

// file: sim/pews_host_test.sv
// self-checking bench for the paged EEPROM write controller
`timescale 1ns/1ps
`default_nettype none
module pews_host_test;
    import pews_pkg::*;
    typedef struct {
        logic [14:0] a;
        logic [7:0]  d;
        logic        last;
        int          gap;
        logic        chk;
        logic [7:0]  exp;
    } pews_row_t;
    localparam int BLC = 40;
    logic         clk, sys_rst, byte_valid, byte_ready, result_valid, busy, stuck;
    pews_byte_t   byte_in;
    pews_result_t result, r;
    pews_pins_t   pins;
    logic [7:0]   mem_dq;
    wire [7:0]    bus = pins.dq_oe_n ? mem_dq : pins.dq_out;
    int           n_mismatch = 0, compares = 0, cyc = 0, last_fall = 0;
    logic [8:0]   page;
    logic [14:0]  rd_addr;
    logic         page_open = 0, rd_seen = 0, we_q = 1, oe_q = 1;
    pews_result_t q [$];
    // rows 3..6: second page, foreign page, then a gap past the load window
    pews_row_t    rows [7] = '{'{15'h0040, 8'hA5, 0, 0, 0, 8'h00}, '{15'h0041, 8'h3C, 0, 0, 0, 8'h00},
        '{15'h007F, 8'h81, 1, 0, 0, 8'h00}, '{15'h0100, 8'h12, 0, 0, 1, 8'h81},
        '{15'h0140, 8'h34, 1, 0, 1, 8'h12}, '{15'h0200, 8'h7E, 0, 0, 1, 8'h34},
        '{15'h0201, 8'h99, 1, 60, 1, 8'h7E}};
    pews_host #(.BYTE_LOAD_CYC(BLC), .WC_STD_CYC(200), .WC_FAST_CYC(200), .FAST_WRITE(1'b0)) dut_u (
        .clk(clk), .sys_rst(sys_rst), .byte_valid(byte_valid), .byte_ready(byte_ready), .byte_in(byte_in),
        .result_valid(result_valid), .result(result), .busy(busy), .pins(pins), .eep_dq_in(bus));
    pews_eeprom_model #(.WC_NS(2000), .ACC_NS(100)) mem_u (
        .pins(pins), .host_dq(bus), .stuck(stuck), .mem_dq(mem_dq));
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : chk
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    task automatic send(input logic [14:0] a, input logic [7:0] d, input logic last);
        int t;
        t = 0;
        @(posedge clk);
        byte_in <= '{addr: a, data: d, last: last};
        byte_valid <= 1'b1;
        @(negedge clk);
        while (byte_ready !== 1'b1 && t < 3000) begin
            @(negedge clk);
            t++;
        end
        if (t >= 3000) chk("byte_ready", 0, 1);
        @(posedge clk);
        byte_valid <= 1'b0;
    endtask : send
    task automatic get_res;
        int t;
        t = 0;
        while (q.size() == 0 && t < 2000) begin
            @(posedge clk);
            t++;
        end
        if (q.size() == 0) chk("result_valid", 0, 1);
        else r = q.pop_front();
    endtask : get_res
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #400000;
        n_mismatch++;
        give_verdict();
    end
    // pins decode from registers, so they are watched on the falling edge
    always @(negedge clk) begin
        cyc++;
        if (result_valid === 1'b1) q.push_back(result);
        if (sys_rst) begin
            page_open = 0;
            rd_seen = 0;
        end else begin
            if (!pins.we_n && !pins.ce_n) chk("oe_n_in_pulse", pins.oe_n, 1);
            if (we_q && !pins.we_n) begin
                if (page_open) chk("page", pins.addr[14:6], page);
                if (page_open) chk("load_gap", cyc - last_fall <= BLC, 1);
                page = pins.addr[14:6];
                page_open = 1;
                last_fall = cyc;
                rd_seen = 0;
            end
            if (oe_q && !pins.oe_n) begin
                if (rd_seen) chk("poll_addr", pins.addr, rd_addr);
                rd_seen = 1;
                rd_addr = pins.addr;
                page_open = 0;
            end
        end
        we_q = pins.we_n;
        oe_q = pins.oe_n;
    end
    initial begin
        sys_rst = 1'b1;
        byte_valid = 1'b0;
        byte_in = '0;
        stuck = 1'b0;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (rows[i]) begin
            repeat (rows[i].gap) @(posedge clk);
            send(rows[i].a, rows[i].d, rows[i].last);
            if (rows[i].chk) begin
                get_res();
                chk("ok_timeout", {r.ok, r.timeout}, 2'b10);
                chk("data", r.data, rows[i].exp);
            end
        end
        for (int i = 0; i < 64; i++) send(15'h0300 + 15'(i), 8'h80 ^ 8'(i), 1'b0);
        get_res();
        chk("data", r.data, 8'h99);
        get_res();
        chk("full_page", {r.ok, r.timeout, r.data}, {2'b10, 8'hBF});
        for (int i = 0; i < 64; i++) chk("stored", mem_u.mem[32'h0300 + i], 8'h80 ^ 8'(i));
        stuck <= 1'b1;
        send(15'h0400, 8'h55, 1'b1);
        get_res();
        chk("timeout", {r.ok, r.timeout}, 2'b01);
        stuck <= 1'b0;
        send(15'h0500, 8'h01, 1'b0);
        repeat (2) @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk("reset_pins", {pins.ce_n, pins.oe_n, pins.we_n, pins.dq_oe_n, busy, byte_ready, result_valid}, 7'h7A);
        @(posedge clk);
        sys_rst <= 1'b0;
        send(15'h0600, 8'h42, 1'b1);
        get_res();
        chk("after_reset", {r.ok, r.data}, {1'b1, 8'h42});
        give_verdict();
    end
endmodule : pews_host_test
`default_nettype wire
